//--- hdl/pin_config_consts.vh
// Purpose: constants for the pad and output-gating configuration block
// Assumes: byte-wide registers, index 0 and 1 chosen locally
// Notes: definitions only
`ifndef PIN_CONFIG_CONSTS_VH
`define PIN_CONFIG_CONSTS_VH
`define OE_CFG_INDEX 1'h0
`define PAD_CFG_INDEX 1'h1
`define OE_CFG_RESET 8'h10
`define OE_CFG_WRITE_MASK 8'h39
`define PAD_CFG_RESET 8'h2f
`define BIT_OE_SEL 0
`define BIT_OE_POL 3
`define BIT_ENABLE_PIN_PULLUP_EN 4
`define BIT_ENABLE_PIN_PULLDOWN_EN 5
`define BIT_SERIAL_CLOCK_PULLUP_EN 0
`define BIT_SERIAL_DATA_PULLUP_EN 1
`define OD_LSB 2
`define OD_MSB 3
`define PP_LSB 4
`define PP_MSB 5
`define ST_LSB 6
`define ST_MSB 7
`define STARTUP_APLL 2'h0
`define STARTUP_DPLL 2'h1
`define STARTUP_NONE 2'h2
`define OE_SEL_RESET 1'h0
`define OE_POL_RESET 1'h0
`define ENABLE_PIN_PULLUP_EN_RESET 1'h1
`define ENABLE_PIN_PULLDOWN_EN_RESET 1'h0
`define STARTUP_RESET 2'h0
`define PP_RESET 2'h2
`define OD_RESET 2'h3
`define SERIAL_DATA_PULLUP_EN_RESET 1'h1
`define SERIAL_CLOCK_PULLUP_EN_RESET 1'h1
`define RDATA_RESET 8'h00
`define ENABLE_RESET 1'h0
`define OE_RSVD_FILL 2'h0
`endif

//--- hdl/sync2.v
// Purpose: two-flop synchroniser for one level
// Assumes: asynchronous active-high reset
// Notes: first stage read only by the second
`timescale 1ns/100ps
module sync2 #(
	parameter RESET_VALUE = 1'b0
) (
	input wire clk,
	input wire reset,
	input wire d,
	output reg q
);
	reg meta;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			meta <= RESET_VALUE;
			q <= RESET_VALUE;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

//--- hdl/startup_gate.v
// Purpose: holds clock outputs off at startup until chosen lock asserts; none mode releases at once
// Assumes: lock inputs already synchronised
// Notes: once released it stays released until reset
`timescale 1ns/100ps
`include "pin_config_consts.vh"
module startup_gate (
	input wire clk,
	input wire reset,
	input wire [1:0] startupMode,
	input wire apllLock,
	input wire dpllLock,
	output reg released
);
	reg released_next;
	always @* begin
		released_next = released;
		case (startupMode)
			`STARTUP_APLL: begin
				if (apllLock) released_next = 1'b1;
			end
			`STARTUP_DPLL: begin
				if (dpllLock) released_next = 1'b1;
			end
			`STARTUP_NONE: begin
				released_next = 1'b1;
			end
			default: begin
				released_next = released; // reserved code: hold whatever state
			end
		endcase
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			released <= 1'b0;
		end else begin
			released <= released_next;
		end
	end
endmodule

//--- hdl/pin_config_output_gating.v
// Purpose: pad configuration and clock output gating registers
// Assumes: internal byte register port, shared pin and locks asynchronous
// Notes: outputs registered; lock released only once per reset
`timescale 1ns/100ps
`include "pin_config_consts.vh"
module pin_config_output_gating (
	input wire clk,
	input wire reset,
	input wire regWrite,
	input wire regRead,
	input wire regIndex,
	input wire [7:0] regWdata,
	output reg [7:0] regRdata,
	input wire spiMode,
	input wire sharedEnableSelectPin,
	input wire apllLockAsync,
	input wire dpllLockAsync,
	input wire statusPinOpenDrainEn,
	output reg clockOutputEnable,
	output reg enablePinPulldownEn,
	output reg enablePinPullupEn,
	output reg serialDataPullupEn,
	output reg serialClockPullupEn,
	output reg [1:0] statusPinStrength,
	output reg [1:0] serialDataStrength
);
	wire oeWrite;
	wire padWrite;
	reg oeSel_reg;
	reg oeSel_next;
	reg oePol_reg;
	reg oePol_next;
	reg oePullup_reg;
	reg oePullup_next;
	reg oePulldown_reg;
	reg oePulldown_next;
	reg [1:0] startupMode_reg;
	reg [1:0] startupMode_next;
	reg [1:0] pushPull_reg;
	reg [1:0] pushPull_next;
	reg [1:0] openDrain_reg;
	reg [1:0] openDrain_next;
	reg dataPullup_reg;
	reg dataPullup_next;
	reg clockPullup_reg;
	reg clockPullup_next;
	wire [7:0] oeReadback;
	wire [7:0] padReadback;
	reg [7:0] readData_next;
	reg [1:0] statusStrength_next;
	wire pinSync;
	wire apllLock;
	wire dpllLock;
	wire released;
	wire pinActive;
	wire pinGateOk;
	wire gateOk;

	sync2 #(.RESET_VALUE(1'b1)) pinSyncInst (
		.clk(clk),
		.reset(reset),
		.d(sharedEnableSelectPin),
		.q(pinSync)
	);
	sync2 #(.RESET_VALUE(1'b0)) apllSyncInst (
		.clk(clk),
		.reset(reset),
		.d(apllLockAsync),
		.q(apllLock)
	);
	sync2 #(.RESET_VALUE(1'b0)) dpllSyncInst (
		.clk(clk),
		.reset(reset),
		.d(dpllLockAsync),
		.q(dpllLock)
	);
	startup_gate startupGateInst (
		.clk(clk),
		.reset(reset),
		.startupMode(startupMode_reg),
		.apllLock(apllLock),
		.dpllLock(dpllLock),
		.released(released)
	);

	// one byte register per index
	assign oeWrite = regWrite & (regIndex == `OE_CFG_INDEX);
	assign padWrite = regWrite & (regIndex == `PAD_CFG_INDEX);

	always @* begin
		oeSel_next = oeSel_reg;
		if (oeWrite) begin
			oeSel_next = regWdata[`BIT_OE_SEL];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			oeSel_reg <= `OE_SEL_RESET;
		end else begin
			oeSel_reg <= oeSel_next;
		end
	end

	always @* begin
		oePol_next = oePol_reg;
		if (oeWrite) begin
			oePol_next = regWdata[`BIT_OE_POL];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			oePol_reg <= `OE_POL_RESET;
		end else begin
			oePol_reg <= oePol_next;
		end
	end

	always @* begin
		oePullup_next = oePullup_reg;
		if (oeWrite) begin
			oePullup_next = regWdata[`BIT_ENABLE_PIN_PULLUP_EN];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			oePullup_reg <= `ENABLE_PIN_PULLUP_EN_RESET;
		end else begin
			oePullup_reg <= oePullup_next;
		end
	end

	always @* begin
		oePulldown_next = oePulldown_reg;
		if (oeWrite) begin
			oePulldown_next = regWdata[`BIT_ENABLE_PIN_PULLDOWN_EN];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			oePulldown_reg <= `ENABLE_PIN_PULLDOWN_EN_RESET;
		end else begin
			oePulldown_reg <= oePulldown_next;
		end
	end

	// host must not write the reserved code; it would freeze the startup gate
	always @* begin
		startupMode_next = startupMode_reg;
		if (padWrite) begin
			startupMode_next = regWdata[`ST_MSB:`ST_LSB];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			startupMode_reg <= `STARTUP_RESET;
		end else begin
			startupMode_reg <= startupMode_next;
		end
	end

	always @* begin
		pushPull_next = pushPull_reg;
		if (padWrite) begin
			pushPull_next = regWdata[`PP_MSB:`PP_LSB];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pushPull_reg <= `PP_RESET;
		end else begin
			pushPull_reg <= pushPull_next;
		end
	end

	always @* begin
		openDrain_next = openDrain_reg;
		if (padWrite) begin
			openDrain_next = regWdata[`OD_MSB:`OD_LSB];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			openDrain_reg <= `OD_RESET;
		end else begin
			openDrain_reg <= openDrain_next;
		end
	end

	always @* begin
		dataPullup_next = dataPullup_reg;
		if (padWrite) begin
			dataPullup_next = regWdata[`BIT_SERIAL_DATA_PULLUP_EN];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			dataPullup_reg <= `SERIAL_DATA_PULLUP_EN_RESET;
		end else begin
			dataPullup_reg <= dataPullup_next;
		end
	end

	always @* begin
		clockPullup_next = clockPullup_reg;
		if (padWrite) begin
			clockPullup_next = regWdata[`BIT_SERIAL_CLOCK_PULLUP_EN];
		end
	end
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			clockPullup_reg <= `SERIAL_CLOCK_PULLUP_EN_RESET;
		end else begin
			clockPullup_reg <= clockPullup_next;
		end
	end

	// reserved bits never store, so they read back as zero
	assign oeReadback = {`OE_RSVD_FILL, oePulldown_reg, oePullup_reg, oePol_reg, `OE_RSVD_FILL, oeSel_reg};
	assign padReadback = {startupMode_reg, pushPull_reg, openDrain_reg, dataPullup_reg, clockPullup_reg};

	// read in the cycle of a write returns the value before it
	always @* begin
		readData_next = regRdata;
		if (regRead) begin
			case (regIndex)
				`OE_CFG_INDEX: begin
					readData_next = oeReadback;
				end
				`PAD_CFG_INDEX: begin
					readData_next = padReadback;
				end
				default: begin
					readData_next = regRdata;
				end
			endcase
		end
	end

	assign pinActive = pinSync ^ oePol_reg;
	// select 1 or spi mode makes the pin irrelevant
	assign pinGateOk = oeSel_reg | spiMode | pinActive;
	assign gateOk = pinGateOk & released;

	// strength field follows the status pin's driver type
	always @* begin
		statusStrength_next = pushPull_reg;
		if (statusPinOpenDrainEn) begin
			statusStrength_next = openDrain_reg;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			regRdata <= `RDATA_RESET;
		end else begin
			regRdata <= readData_next;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			clockOutputEnable <= `ENABLE_RESET;
		end else begin
			clockOutputEnable <= gateOk;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			enablePinPulldownEn <= `ENABLE_PIN_PULLDOWN_EN_RESET;
		end else begin
			enablePinPulldownEn <= oePulldown_reg;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			enablePinPullupEn <= `ENABLE_PIN_PULLUP_EN_RESET;
		end else begin
			enablePinPullupEn <= oePullup_reg;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			serialDataPullupEn <= `SERIAL_DATA_PULLUP_EN_RESET;
		end else begin
			serialDataPullupEn <= dataPullup_reg;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			serialClockPullupEn <= `SERIAL_CLOCK_PULLUP_EN_RESET;
		end else begin
			serialClockPullupEn <= clockPullup_reg;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			statusPinStrength <= `PP_RESET;
		end else begin
			statusPinStrength <= statusStrength_next;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			serialDataStrength <= `PP_RESET;
		end else begin
			serialDataStrength <= pushPull_reg;
		end
	end
endmodule

//--- verif/board_model.sv
// Purpose: board side driving shared pin and lock levels
// Assumes: levels change just after an edge
// Notes: bit 0 pin, 1 analog lock, 2 digital lock
`timescale 1ns/100ps
module board_model (input wire clk, input wire [2:0] want, output reg [2:0] drv);
	initial drv = 3'h0;
	always @(posedge clk) drv <= want;
endmodule

//--- verif/pcog_chk.sv
// Purpose: port checker for output gating
// Assumes: outputs settle two edges after a write
// Notes: register state seen only through writes
`timescale 1ns/100ps
module pcog_chk (input wire clk, input wire reset, input wire regWrite, input wire regIndex,
	input wire [7:0] regWdata, input wire statusPinOpenDrainEn, input wire clockOutputEnable,
	input wire enablePinPulldownEn, input wire enablePinPullupEn, input wire serialDataPullupEn,
	input wire serialClockPullupEn, input wire [1:0] statusPinStrength, input wire [1:0] serialDataStrength);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence oeW; regWrite && !regIndex ##1 !regWrite; endsequence
	sequence padW; regWrite && regIndex ##1 !regWrite; endsequence
	sequence odW; padW ##0 statusPinOpenDrainEn[*2]; endsequence
	sequence ppW; padW ##0 !statusPinOpenDrainEn[*2]; endsequence
	sequence resetOuts; !clockOutputEnable && enablePinPullupEn && !enablePinPulldownEn; endsequence
	pull_down_a: assert property (oeW |=> enablePinPulldownEn == $past(regWdata[5], 2)) else $error("pd");
	pull_up_a: assert property (oeW |=> enablePinPullupEn == $past(regWdata[4], 2)) else $error("pu");
	data_pull_a: assert property (padW |=> serialDataPullupEn == $past(regWdata[1], 2)) else $error("sda");
	clk_pull_a: assert property (padW |=> serialClockPullupEn == $past(regWdata[0], 2)) else $error("scl");
	pp_drive_a: assert property (padW |=> serialDataStrength == $past(regWdata[5:4], 2)) else $error("pp");
	od_status_a: assert property (odW |=> statusPinStrength == $past(regWdata[3:2], 3)) else $error("od");
	pp_status_a: assert property (ppW |=> statusPinStrength == $past(regWdata[5:4], 3)) else $error("pps");
	reset_state_a: assert property ($fell(reset) |-> resetOuts) else $error("rst");
	cover property (oeW);
	cover property (padW);
	cover property ($rose(clockOutputEnable));
endmodule
bind pin_config_output_gating pcog_chk u_chk (.*);

//--- verif/pin_config_output_gating_tb.sv
// Purpose: directed bench for output gating
// Assumes: lock and pin settle within eight edges
// Notes: each startup mode gets its own reset
`timescale 1ns/100ps
module pin_config_output_gating_tb;
	reg clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, regIndex = 1'b0, spiMode = 1'b0;
	reg statusPinOpenDrainEn = 1'b0;
	reg [7:0] regWdata = 8'h00;
	reg [2:0] want = 3'h0;
	wire [2:0] drv;
	wire [7:0] regRdata;
	wire clockOutputEnable, enablePinPulldownEn, enablePinPullupEn, serialDataPullupEn, serialClockPullupEn;
	wire [1:0] statusPinStrength, serialDataStrength;
	integer n_fail = 0, total_checks = 0;
	board_model u_brd (.clk, .want, .drv);
	pin_config_output_gating u_dut (.clk, .reset, .regWrite, .regRead, .regIndex, .regWdata, .regRdata, .spiMode,
		.sharedEnableSelectPin(drv[0]), .apllLockAsync(drv[1]), .dpllLockAsync(drv[2]), .statusPinOpenDrainEn,
		.clockOutputEnable, .enablePinPulldownEn, .enablePinPullupEn, .serialDataPullupEn, .serialClockPullupEn,
		.statusPinStrength, .serialDataStrength);
	initial forever #50 clk = ~clk;
	task chk(input string n, input [7:0] s, input [7:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h saw %h", n, e, s);
		end
	endtask
	task rst;
		reset <= 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input i, input [7:0] d);
		regWrite <= 1'b1;
		regIndex <= i;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input i, input [7:0] e);
		regRead <= 1'b1;
		regIndex <= i;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
		chk("rdata", regRdata, e);
	endtask
	// fixed wait: pin path takes four edges, lock path five
	task en(input e);
		repeat (8) @(posedge clk);
		chk("enable", {7'h0, clockOutputEnable}, {7'h0, e});
	endtask
	task t_regs;
		rst;
		rd(1'h0, 8'h10);
		rd(1'h1, 8'h2f);
		wr(1'h0, 8'hff);
		rd(1'h0, 8'h39);
		statusPinOpenDrainEn <= 1'b1;
		wr(1'h1, 8'h18);
		en(1'b0);
		chk("od", {6'h0, statusPinStrength}, 8'h02);
		chk("oepull", {6'h0, enablePinPulldownEn, enablePinPullupEn}, 8'h03);
		chk("padpull", {6'h0, serialDataPullupEn, serialClockPullupEn}, 8'h00);
		chk("datastr", {6'h0, serialDataStrength}, 8'h01);
		rd(1'h1, 8'h18);
		statusPinOpenDrainEn <= 1'b0;
		en(1'b0);
		chk("pp", {6'h0, statusPinStrength}, 8'h01);
		$display("regs end");
	endtask
	task t_mode0;
		rst;
		want <= 3'h1;
		en(1'b0);
		want <= 3'h3;
		en(1'b1);
		want <= 3'h2;
		en(1'b0);
		wr(1'h0, 8'h18);
		en(1'b1);
		wr(1'h0, 8'h11);
		en(1'b1);
		wr(1'h0, 8'h10);
		spiMode <= 1'b1;
		en(1'b1);
		spiMode <= 1'b0;
		en(1'b0);
		$display("mode0 end");
	endtask
	task t_mode12;
		// locks low through reset so the default analog mode cannot release early
		want <= 3'h0;
		rst;
		wr(1'h1, 8'h6f);
		want <= 3'h3;
		en(1'b0);
		want <= 3'h7;
		en(1'b1);
		want <= 3'h1;
		rst;
		wr(1'h1, 8'haf);
		en(1'b1);
		$display("mode12 end");
	endtask
	task report_and_stop;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		t_regs;
		t_mode0;
		t_mode12;
		report_and_stop;
	end
endmodule
